// *** design/sdc_ctrl.sv ***
/*
  SDRAM direct-command issue path and memory-setup register, APB3 slave.
  Assumes the controller state, supported chip count, command spacing and datapath
  status flags are produced by surrounding logic on the same core clock.
*/
// Summary of operation
// - software issues mode, NOP, precharge, refresh commands
// - command writes only in config or low-power
// - command code is bit22 with bits19-18
// - chip field drives the chip selects
// - mode access drives bank and address lines
// - setup register access only config/low-power
// - bit31 enables automatic self-refresh entry
// - forced precharge after programmed timeout
// - active chips limited to supported count
// - qos slice selects four read-id bits
// - burst code gives accesses per command
// - clock-stop bit halts idle memory clock
// - auto power-down drops cke after idle period
// - autoprecharge position selects address 10 or 8
// - row width is 11 plus code
// - column width is 8 plus code
// - controller state reported as two-bit code
// - supported chip count reported as two bits
`timescale 1ns/1ns
`default_nettype none
module sdc_ctrl (
  input  wire logic               i_core_clk,
  input  wire logic               i_rst_n,
  input  wire logic               i_psel,
  input  wire logic               i_penable,
  input  wire logic               i_pwrite,
  input  wire logic [7:0]         i_paddr,
  input  wire logic [31:0]        i_pwdata,
  output var  logic [31:0]        o_prdata,
  output var  logic               o_pready,
  output var  logic               o_pslverr,
  input  wire logic [1:0]         i_ctrl_state,
  input  wire logic [1:0]         i_chips_supported,
  input  wire logic [6:0]         i_cmd_gap,
  input  wire logic               i_cmd_fifo_empty,
  input  wire logic               i_mem_busy,
  input  wire logic               i_bank_open,
  input  wire logic [7:0]         i_arid,
  output var  sdc_pkg::sdc_pins_t o_pins,
  output var  logic               o_cmd_valid,
  output var  logic [3:0]         o_qos_idx,
  output var  logic [4:0]         o_burst_len,
  output var  logic [4:0]         o_row_width,
  output var  logic [3:0]         o_col_width,
  output var  logic [3:0]         o_ap_addr_bit,
  output var  logic [1:0]         o_active_chips,
  output var  logic               o_mem_clk_en,
  output var  logic               o_force_precharge,
  output var  logic               o_selfref_req
);
  import sdc_pkg::*;

  function automatic logic state_ok(input logic [1:0] st);
    state_ok = (st == ST_CONFIG) || (st == ST_LOWPOWER);
  endfunction

  // builds the pin pattern of one direct command
  function automatic sdc_pins_t cmd_pins(input logic [31:0] w, input logic ap_alt);
    sdc_pins_t  p;
    logic [2:0] op;
    logic [1:0] chip;
    p    = PINS_IDLE;
    op   = {w[CMD_OP_HI_BIT], w[CMD_OP_LSB +: 2]};
    chip = w[CMD_CHIP_LSB +: 2];
    p.cs_n = ~(4'h1 << chip);
    case (op)
      OP_PREALL: begin
        {p.ras_n, p.cas_n, p.we_n} = 3'h2;
        p.addr[ap_alt ? AP_ADDR_ALT : AP_ADDR_STD] = 1'b1;
      end
      OP_REFRESH: begin
        {p.ras_n, p.cas_n, p.we_n} = 3'h1;
      end
      OP_MODE: begin
        {p.ras_n, p.cas_n, p.we_n} = 3'h0;
        p.ba   = w[CMD_BA_LSB +: 2];
        p.addr = w[CMD_MA_LSB +: 14];
      end
      OP_DPD: begin
        // deep power-down: burst-terminate pattern with cke low
        {p.ras_n, p.cas_n, p.we_n} = 3'h6;
        p.cke = 1'b0;
      end
      default: begin
        // NOP; the unused codes fall back to it rather than risk a stray command
        {p.ras_n, p.cas_n, p.we_n} = 3'h7;
      end
    endcase
    cmd_pins = p;
  endfunction

  function automatic logic [3:0] qos_slice(input logic [7:0] id, input logic [2:0] code);
    logic [2:0] sh;
    sh = (code > QOS_MAX_SHIFT) ? QOS_MAX_SHIFT : code;
    qos_slice = 4'(id >> sh);
  endfunction

  logic      access;
  logic      allowed;
  logic      cmd_take;
  logic      cfg_wr_ok;
  logic      sub_cke;
  sdc_cfg_t  cfg_q;
  sdc_cfg_t  cfg_d;
  logic [31:0] prdata_d;
  logic      pready_d;
  logic      pslverr_d;

  // every access cycle acts until o_pready is high; o_pready high marks the completing cycle
  assign access  = i_psel && i_penable && !o_pready;
  assign allowed = state_ok(i_ctrl_state);

  // register port
  sdc_seq_t  seq_q;
  sdc_seq_t  seq_d;

  always_comb begin
    pready_d  = 1'b0;
    pslverr_d = 1'b0;
    prdata_d  = 32'h0000_0000;
    cfg_d     = cfg_q;
    cmd_take  = 1'b0;
    cfg_wr_ok = 1'b0;
    if (access) begin
      pready_d = 1'b1;
      case (i_paddr)
        ADDR_STATUS: begin
          prdata_d[STS_STATE_LSB +: 2] = i_ctrl_state;
          prdata_d[STS_CHIPS_LSB +: 2] = i_chips_supported;
          pslverr_d = i_pwrite;
        end
        ADDR_CMD: begin
          if (!i_pwrite || !allowed) begin
            pslverr_d = 1'b1;
          end else if (seq_q != SEQ_IDLE) begin
            // previous command still spacing out: wait the bus
            pready_d = 1'b0;
          end else begin
            cmd_take = 1'b1;
          end
        end
        ADDR_CFG: begin
          if (!allowed) begin
            pslverr_d = 1'b1;
          end else if (i_pwrite) begin
            cfg_wr_ok = 1'b1;
            cfg_d     = sdc_cfg_t'(i_pwdata);
            if (cfg_d.active_chips > i_chips_supported) begin
              cfg_d.active_chips = i_chips_supported;
            end
          end else begin
            prdata_d = cfg_q;
          end
        end
        default: begin
          pslverr_d = 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_pready  <= 1'b0;
      o_pslverr <= 1'b0;
      o_prdata  <= 32'h0000_0000;
      cfg_q     <= sdc_cfg_t'(CFG_RESET);
    end else begin
      o_pready  <= pready_d;
      o_pslverr <= pslverr_d;
      o_prdata  <= prdata_d;
      cfg_q     <= cfg_d;
    end
  end

  // command sequencer
  logic [6:0] gap_q;
  logic [6:0] gap_d;
  logic       dpd_q;
  logic       dpd_d;
  sdc_pins_t  pins_d;
  logic       valid_d;

  always_comb begin
    seq_d   = seq_q;
    gap_d   = gap_q;
    dpd_d   = dpd_q;
    pins_d  = PINS_IDLE;
    valid_d = 1'b0;
    case (seq_q)
      SEQ_IDLE: begin
        if (cmd_take) begin
          seq_d   = SEQ_ISSUE;
          gap_d   = i_cmd_gap;
          valid_d = 1'b1;
          pins_d  = cmd_pins(i_pwdata, cfg_q.autoprecharge_position);
          // any later command other than deep power-down leaves deep power-down
          dpd_d   = ({i_pwdata[CMD_OP_HI_BIT], i_pwdata[CMD_OP_LSB +: 2]} == OP_DPD);
        end
      end
      SEQ_ISSUE: begin
        seq_d = SEQ_GAP;
      end
      SEQ_GAP: begin
        // only the timing-register spacing is kept; longer waits are software's job
        if (gap_q == GAP_RESET) begin
          seq_d = SEQ_IDLE;
        end else begin
          gap_d = gap_q - 7'h01;
        end
      end
      default: begin
        seq_d = SEQ_IDLE;
      end
    endcase
    pins_d.cke = sub_cke && !dpd_d;
  end

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      seq_q       <= SEQ_IDLE;
      gap_q       <= GAP_RESET;
      dpd_q       <= 1'b0;
      o_pins      <= PINS_IDLE;
      o_cmd_valid <= 1'b0;
    end else begin
      seq_q       <= seq_d;
      gap_q       <= gap_d;
      dpd_q       <= dpd_d;
      o_pins      <= pins_d;
      o_cmd_valid <= valid_d;
    end
  end

  // setup decodes, registered so the datapath sees clean levels
  logic [3:0] qos_d;
  logic [4:0] burst_d;
  logic [4:0] row_d;
  logic [3:0] col_d;
  logic [3:0] ap_d;

  always_comb begin
    qos_d   = qos_slice(i_arid, cfg_q.qos_slice);
    burst_d = 5'h01 << ((cfg_q.burst_code > BURST_MAX_CODE) ? BURST_MAX_CODE : cfg_q.burst_code);
    row_d   = ROW_BASE_BITS + 5'(cfg_q.row_code);
    col_d   = COL_BASE_BITS + 4'(cfg_q.col_code);
    ap_d    = cfg_q.autoprecharge_position ? AP_ADDR_ALT : AP_ADDR_STD;
  end

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_qos_idx      <= 4'h0;
      o_burst_len    <= 5'h01;
      o_row_width    <= ROW_BASE_BITS;
      o_col_width    <= COL_BASE_BITS;
      o_ap_addr_bit  <= AP_ADDR_STD;
      o_active_chips <= 2'h0;
    end else begin
      o_qos_idx      <= qos_d;
      o_burst_len    <= burst_d;
      o_row_width    <= row_d;
      o_col_width    <= col_d;
      o_ap_addr_bit  <= ap_d;
      o_active_chips <= cfg_q.active_chips;
    end
  end

  sdc_idle_timer u_idle (
    .i_core_clk    (i_core_clk),
    .i_rst_n       (i_rst_n),
    .i_cfg         (cfg_q),
    .i_fifo_empty  (i_cmd_fifo_empty),
    .i_busy        (i_mem_busy),
    .i_bank_open   (i_bank_open),
    .o_cke         (sub_cke),
    .o_clk_en      (o_mem_clk_en),
    .o_force_pre   (o_force_precharge),
    .o_selfref_req (o_selfref_req)
  );

  // helper state for spacing checks
  logic [7:0] since_q;
  logic [6:0] prev_gap_q;
  logic       seen_q;

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      since_q    <= 8'h00;
      prev_gap_q <= GAP_RESET;
      seen_q     <= 1'b0;
    end else begin
      since_q    <= o_cmd_valid ? 8'h01 : ((since_q == 8'hff) ? since_q : since_q + 8'h01);
      prev_gap_q <= o_cmd_valid ? gap_q : prev_gap_q;
      seen_q     <= seen_q || o_cmd_valid;
    end
  end

  default clocking cb_core @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_n);

  sequence s_take;
    cmd_take;
  endsequence

  sequence s_issue_gap;
    o_cmd_valid && (seq_q == SEQ_ISSUE) ##1 !o_cmd_valid && (seq_q == SEQ_GAP);
  endsequence

  property p_issue_once;
    s_take |=> s_issue_gap;
  endproperty

  property p_refused_cmd;
    (access && i_paddr == ADDR_CMD && i_pwrite && !allowed) |=> o_pslverr && o_pready && !o_cmd_valid;
  endproperty

  property p_spacing;
    (o_cmd_valid && seen_q) |-> since_q >= 8'(prev_gap_q) + 8'h03;
  endproperty

  property p_mode_pins;
    (s_take and (i_pwdata[CMD_OP_HI_BIT +: 1] == 1'b0) and (i_pwdata[CMD_OP_LSB +: 2] == 2'h2))
      |=> {o_pins.ras_n, o_pins.cas_n, o_pins.we_n} == 3'h0
          && o_pins.ba == $past(i_pwdata[CMD_BA_LSB +: 2])
          && o_pins.addr == $past(i_pwdata[CMD_MA_LSB +: 14]);
  endproperty

  chk_cmd_issue_once: assert property (p_issue_once)
    else $error("accepted command did not issue exactly once");
  chk_cmd_refused: assert property (p_refused_cmd)
    else $error("command write outside config/low-power was not refused");
  chk_cmd_spacing: assert property (p_spacing)
    else $error("commands closer than the timing spacing");
  chk_mode_pins: assert property (p_mode_pins)
    else $error("mode register access drove wrong bank or address");
  chk_chip_select: assert property (s_take |=> o_pins.cs_n == ~(4'h1 << $past(i_pwdata[CMD_CHIP_LSB +: 2])))
    else $error("chip select does not follow the chip field");
  chk_refresh_code: assert property ((s_take and i_pwdata[CMD_OP_HI_BIT] == 1'b0 and i_pwdata[CMD_OP_LSB +: 2] == 2'h1)
      |=> {o_pins.ras_n, o_pins.cas_n, o_pins.we_n} == 3'h1)
    else $error("auto-refresh code produced wrong pin pattern");
  chk_cfg_guard: assert property ((access && i_paddr == ADDR_CFG && i_pwrite && !allowed) |=> $stable(cfg_q))
    else $error("setup register changed by a refused write");
  chk_chip_clamp: assert property (cfg_wr_ok |=> cfg_q.active_chips <= $past(i_chips_supported))
    else $error("active chips above supported count");
  chk_cfg_readback: assert property ((access && i_paddr == ADDR_CFG && !i_pwrite && allowed)
      |=> o_pready && !o_pslverr && o_prdata == $past(cfg_q))
    else $error("setup register read did not return stored value");

endmodule
`default_nettype wire

// *** design/sdc_idle_timer.sv ***
/*
  Idle-driven power controls: auto power-down, memory clock stop, forced precharge
  timeout and automatic self-refresh request.
  Assumes command-FIFO empty, access busy and bank-open flags come from logic on the same clock.
*/
`timescale 1ns/1ns
`default_nettype none
module sdc_idle_timer (
  input  wire logic              i_core_clk,
  input  wire logic              i_rst_n,
  input  wire sdc_pkg::sdc_cfg_t i_cfg,
  input  wire logic              i_fifo_empty,
  input  wire logic              i_busy,
  input  wire logic              i_bank_open,
  output var  logic              o_cke,
  output var  logic              o_clk_en,
  output var  logic              o_force_pre,
  output var  logic              o_selfref_req
);
  import sdc_pkg::*;

  logic [5:0] idle_q;
  logic [5:0] idle_d;
  logic [6:0] fp_q;
  logic [6:0] fp_d;
  logic       idle_done;
  logic       cke_d;
  logic       clk_en_d;
  logic       fp_pulse_d;
  logic       sr_d;

  always_comb begin
    // >= so a period lowered below the running count still counts as expired
    idle_done  = i_fifo_empty && (idle_q >= i_cfg.pd_period);
    idle_d     = !i_fifo_empty ? IDLE_CNT_RESET : (idle_done ? idle_q : idle_q + 6'h01);
    cke_d      = !(i_cfg.auto_pd && idle_done);
    clk_en_d   = !(i_cfg.stop_clk && !i_busy);
    sr_d       = i_cfg.auto_selfrefresh_entry && idle_done;
    fp_pulse_d = 1'b0;
    fp_d       = FP_CNT_RESET;
    if (i_cfg.forced_precharge_on && i_bank_open && !i_busy) begin
      if (fp_q >= i_cfg.forced_precharge_timeout) begin
        fp_pulse_d = 1'b1;
      end else begin
        fp_d = fp_q + 7'h01;
      end
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      idle_q        <= IDLE_CNT_RESET;
      fp_q          <= FP_CNT_RESET;
      o_cke         <= 1'b1;
      o_clk_en      <= 1'b1;
      o_force_pre   <= 1'b0;
      o_selfref_req <= 1'b0;
    end else begin
      idle_q        <= idle_d;
      fp_q          <= fp_d;
      o_cke         <= cke_d;
      o_clk_en      <= clk_en_d;
      o_force_pre   <= fp_pulse_d;
      o_selfref_req <= sr_d;
    end
  end

  default clocking cb_idle @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_n);

  chk_cke_wake_busy: assert property (!i_fifo_empty |=> o_cke)
    else $error("cke low while command fifo held work");
  chk_clk_run_busy: assert property (i_busy |=> o_clk_en)
    else $error("memory clock stopped during an access");
  chk_fp_cause: assert property (o_force_pre |-> $past(i_bank_open && i_cfg.forced_precharge_on))
    else $error("forced precharge without enable and open bank");
  chk_sr_gate: assert property (!i_cfg.auto_selfrefresh_entry |=> !o_selfref_req)
    else $error("self-refresh requested while disabled");

endmodule
`default_nettype wire

// *** shared/sdc_pkg.sv ***
/*
  Shared constants and types for the SDRAM direct-command and memory-setup block:
  register offsets, field layouts, command codes, controller states and the pin bundle.
  Assumes one core clock domain and an APB3 register port with byte addresses.
*/
`default_nettype none
package sdc_pkg;

  // register byte offsets and setup reset value
  localparam logic [7:0]  ADDR_STATUS     = 8'h00;
  localparam logic [7:0]  ADDR_CMD        = 8'h08;
  localparam logic [7:0]  ADDR_CFG        = 8'h0c;
  localparam logic [31:0] CFG_RESET       = 32'h0001_0020;

  // command register layout
  localparam int          CMD_OP_HI_BIT   = 22;
  localparam int          CMD_CHIP_LSB    = 20;
  localparam int          CMD_OP_LSB      = 18;
  localparam int          CMD_BA_LSB      = 16;
  localparam int          CMD_MA_LSB      = 0;

  // status register layout
  localparam int          STS_STATE_LSB   = 0;
  localparam int          STS_CHIPS_LSB   = 7;

  // command codes
  localparam logic [2:0]  OP_PREALL       = 3'h0;
  localparam logic [2:0]  OP_REFRESH      = 3'h1;
  localparam logic [2:0]  OP_MODE         = 3'h2;
  localparam logic [2:0]  OP_NOP          = 3'h3;
  localparam logic [2:0]  OP_DPD          = 3'h4;

  // controller states
  localparam logic [1:0]  ST_CONFIG       = 2'h0;
  localparam logic [1:0]  ST_READY        = 2'h1;
  localparam logic [1:0]  ST_PAUSED       = 2'h2;
  localparam logic [1:0]  ST_LOWPOWER     = 2'h3;

  // decode limits and bases
  localparam logic [2:0]  QOS_MAX_SHIFT   = 3'h4;
  localparam logic [2:0]  BURST_MAX_CODE  = 3'h4;
  localparam logic [4:0]  ROW_BASE_BITS   = 5'h0b;
  localparam logic [3:0]  COL_BASE_BITS   = 4'h8;
  localparam logic [3:0]  AP_ADDR_STD     = 4'ha;
  localparam logic [3:0]  AP_ADDR_ALT     = 4'h8;

  // counter reset values
  localparam logic [6:0]  GAP_RESET       = 7'h00;
  localparam logic [5:0]  IDLE_CNT_RESET  = 6'h00;
  localparam logic [6:0]  FP_CNT_RESET    = 7'h00;

  typedef struct packed {
    logic       auto_selfrefresh_entry;
    logic [6:0] forced_precharge_timeout;
    logic       forced_precharge_on;
    logic [1:0] active_chips;
    logic [2:0] qos_slice;
    logic [2:0] burst_code;
    logic       stop_clk;
    logic       auto_pd;
    logic [5:0] pd_period;
    logic       autoprecharge_position;
    logic [2:0] row_code;
    logic [2:0] col_code;
  } sdc_cfg_t;

  typedef struct packed {
    logic        cke;
    logic [3:0]  cs_n;
    logic        ras_n;
    logic        cas_n;
    logic        we_n;
    logic [1:0]  ba;
    logic [13:0] addr;
  } sdc_pins_t;

  localparam sdc_pins_t   PINS_IDLE       = '{cke: 1'b1, cs_n: 4'hf, ras_n: 1'b1, cas_n: 1'b1,
                                              we_n: 1'b1, ba: 2'h0, addr: 14'h0000};

  typedef enum logic [1:0] {
    SEQ_IDLE  = 2'h0,
    SEQ_ISSUE = 2'h1,
    SEQ_GAP   = 2'h3
  } sdc_seq_t;

endpackage
`default_nettype wire

// *** sim/sdc_ctrl_bench.sv ***
/*
  Self-checking bench for sdc_ctrl: APB3 tasks, command and setup scenarios.
  Assumes the SDRAM model beside the block latches every issued command.
*/
`timescale 1ns/1ns
`default_nettype none
module sdc_ctrl_bench;
  import sdc_pkg::*;
  logic        i_core_clk = 1'b0;
  logic        i_rst_n = 1'b0;
  logic        i_psel = 1'b0;
  logic        i_penable = 1'b0;
  logic        i_pwrite = 1'b0;
  logic [7:0]  i_paddr = 8'h00;
  logic [31:0] i_pwdata = 32'h0;
  logic [1:0]  i_ctrl_state = ST_CONFIG;
  logic [1:0]  i_chips_supported = 2'h2;
  logic [6:0]  i_cmd_gap = 7'h05;
  logic        i_cmd_fifo_empty = 1'b0;
  logic        i_mem_busy = 1'b1;
  logic        i_bank_open = 1'b0;
  logic [7:0]  i_arid = 8'ha5;
  logic [31:0] o_prdata, rd;
  logic        o_pready, o_pslverr, o_cmd_valid, er;
  sdc_pins_t   o_pins, last_cmd;
  logic [3:0]  o_qos_idx, o_col_width, o_ap_addr_bit;
  logic [4:0]  o_burst_len, o_row_width;
  logic [1:0]  o_active_chips;
  logic        o_mem_clk_en, o_force_precharge, o_selfref_req;
  logic [7:0]  n_cmds;
  logic        ap_alt = 1'b0;
  int          err_total = 0;
  int          check_count = 0;

  sdc_ctrl sdc_ctrl_i (.i_core_clk, .i_rst_n, .i_psel, .i_penable, .i_pwrite, .i_paddr, .i_pwdata,
    .o_prdata, .o_pready, .o_pslverr, .i_ctrl_state, .i_chips_supported, .i_cmd_gap, .i_cmd_fifo_empty,
    .i_mem_busy, .i_bank_open, .i_arid, .o_pins, .o_cmd_valid, .o_qos_idx, .o_burst_len, .o_row_width,
    .o_col_width, .o_ap_addr_bit, .o_active_chips, .o_mem_clk_en, .o_force_precharge, .o_selfref_req);
  sdc_sdram_model sdc_sdram_model_i (.i_core_clk, .i_rst_n, .i_pins(o_pins), .i_cmd_valid(o_cmd_valid),
    .o_last(last_cmd), .o_cmds(n_cmds));

  always #5 i_core_clk = ~i_core_clk;

  task automatic report_and_stop();
    if (err_total == 0 && check_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e) begin
      err_total++;
      $display("ERROR %0t got %h expected %h", $time, g, e);
    end
  endtask

  // request held until the edge at which ready is seen high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r,
                     output logic e);
    int n;
    i_psel = 1'b1;
    i_pwrite = w;
    i_paddr = a;
    i_pwdata = d;
    @(posedge i_core_clk);
    #1 i_penable = 1'b1;
    n = 0;
    do begin
      @(negedge i_core_clk);
      n++;
    end while (o_pready !== 1'b1 && n < 50);
    if (n >= 50) chk(32'h0, 32'h1);
    r = o_prdata;
    e = o_pslverr;
    @(posedge i_core_clk);
    #1 i_psel = 1'b0;
    i_penable = 1'b0;
    // one idle edge so a following call never re-raises psel in the same time step
    @(posedge i_core_clk);
    #1;
  endtask

  function automatic logic [2:0] rcw(input logic [2:0] op);
    case (op)
      OP_PREALL:  return 3'h2;
      OP_REFRESH: return 3'h1;
      OP_MODE:    return 3'h0;
      OP_DPD:     return 3'h6;
      default:    return 3'h7;
    endcase
  endfunction

  task automatic cmd(input logic [2:0] op, input logic [1:0] ch, input logic [15:0] ma, input logic ok);
    logic [7:0] n;
    n = n_cmds;
    apb(1'b1, ADDR_CMD, {9'h000, op[2], ch, op[1:0], ma[15:14], 2'h0, ma[13:0]}, rd, er);
    chk(er, !ok);
    chk(n_cmds, ok ? n + 8'h01 : n);
    if (ok) begin
      chk({last_cmd.ras_n, last_cmd.cas_n, last_cmd.we_n}, rcw(op));
      chk(last_cmd.cs_n, 4'(~(4'h1 << ch)));
      if (op == OP_MODE) chk({last_cmd.ba, last_cmd.addr}, ma);
      if (op == OP_PREALL) chk(last_cmd.addr, ap_alt ? 14'h0100 : 14'h0400);
    end
  endtask

  task automatic cfgw(input logic [31:0] d);
    apb(1'b1, ADDR_CFG, d, rd, er);
    chk(er, 1'b0);
    @(posedge i_core_clk);
    #1;
  endtask

  initial begin
    int n;
    logic [2:0] c;
    repeat (10) @(posedge i_core_clk);
    #1 i_rst_n = 1'b1;
    apb(1'b0, ADDR_CFG, 32'h0, rd, er);
    chk(rd, 32'h0001_0020);
    chk({o_burst_len, o_row_width, o_col_width, o_ap_addr_bit}, {5'h04, 5'h0f, 4'h8, 4'ha});
    apb(1'b0, ADDR_STATUS, 32'h0, rd, er);
    chk(rd, 32'h0000_0100);
    // codes 5 and up fall back to a harmless nop
    for (int k = 0; k < 6; k++) begin
      cmd(k[2:0], k[1:0], 16'h8123 + 16'(k), 1'b1);
      if (k == 4) chk(o_pins.cke, 1'b0);
    end
    repeat (3) @(posedge i_core_clk);
    #1 chk(o_pins.cke, 1'b1);
    cmd(OP_MODE, 2'h1, 16'h0032, 1'b1);
    cmd(OP_NOP, 2'h0, 16'h0000, 1'b1);
    i_ctrl_state = ST_READY;
    cmd(OP_NOP, 2'h0, 16'h0000, 1'b0);
    apb(1'b1, ADDR_CFG, 32'h0, rd, er);
    chk(er, 1'b1);
    i_ctrl_state = ST_PAUSED;
    apb(1'b0, ADDR_CFG, 32'h0, rd, er);
    chk(er, 1'b1);
    i_ctrl_state = ST_LOWPOWER;
    apb(1'b0, ADDR_CFG, 32'h0, rd, er);
    chk(er, 1'b0);
    chk(rd, 32'h0001_0020);
    apb(1'b0, ADDR_STATUS, 32'h0, rd, er);
    chk(rd, 32'h0000_0103);
    cmd(OP_REFRESH, 2'h2, 16'h0000, 1'b1);
    i_ctrl_state = ST_CONFIG;
    // row code runs to 5, so the top row bit passes the 14 address lines; the other codes stop at 4
    for (int k = 0; k < 6; k++) begin
      c = (k > 4) ? 3'h4 : 3'(k);
      cfgw({9'h000, 2'h0, c, c, 2'h0, 6'h00, k[0], 3'(k), c});
      chk({o_qos_idx, o_burst_len, o_row_width, o_col_width, o_ap_addr_bit},
          {4'(8'ha5 >> c), 5'h01 << c, 5'h0b + 5'(k), 4'h8 + 4'(c), k[0] ? 4'h8 : 4'ha});
    end
    // last setup written above moved the autoprecharge flag to address 8
    ap_alt = 1'b1;
    cmd(OP_PREALL, 2'h3, 16'h0000, 1'b1);
    ap_alt = 1'b0;
    cfgw({9'h000, 2'h3, 21'h000000});
    chk(o_active_chips, 2'h2);
    cfgw({1'b1, 7'h05, 1'b1, 2'h0, 3'h0, 3'h2, 1'b1, 1'b1, 6'h04, 1'b0, 3'h4, 3'h0});
    chk({o_mem_clk_en, o_pins.cke, o_selfref_req}, 3'h6);
    i_mem_busy = 1'b0;
    repeat (2) @(posedge i_core_clk);
    #1 chk(o_mem_clk_en, 1'b0);
    i_mem_busy = 1'b1;
    i_cmd_fifo_empty = 1'b1;
    repeat (2) @(posedge i_core_clk);
    #1 chk({o_mem_clk_en, o_pins.cke}, 2'h3);
    repeat (6) @(posedge i_core_clk);
    #1 chk({o_pins.cke, o_selfref_req}, 2'h1);
    i_mem_busy = 1'b0;
    i_bank_open = 1'b1;
    n = 0;
    while (o_force_precharge !== 1'b1 && n < 20) begin
      @(negedge i_core_clk);
      n++;
    end
    chk(n > 3 && n < 12, 1'b1);
    report_and_stop();
  end

  initial begin
    #200000;
    err_total++;
    report_and_stop();
  end
endmodule
`default_nettype wire

// *** sim/sdc_sdram_model.sv ***
/*
  Behavioural SDRAM at the far side of the command pins: latches each issued command.
  Assumes pins and strobe are registered on the core clock by the block under test.
*/
`timescale 1ns/1ns
`default_nettype none
module sdc_sdram_model (
  input  wire logic               i_core_clk,
  input  wire logic               i_rst_n,
  input  wire sdc_pkg::sdc_pins_t i_pins,
  input  wire logic               i_cmd_valid,
  output var  sdc_pkg::sdc_pins_t o_last,
  output var  logic [7:0]         o_cmds
);
  import sdc_pkg::*;
  // a strobe with no chip selected is no command for any device
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_last <= PINS_IDLE;
      o_cmds <= 8'h00;
    end else if (i_cmd_valid && i_pins.cs_n != 4'hf) begin
      o_last <= i_pins;
      o_cmds <= o_cmds + 8'h01;
    end
  end
endmodule
`default_nettype wire
